// File: verilog/sec_link.sv
// serial instruction shifter and data-output driver clocked by the host serial clock
`timescale 1ns/10ps
`include "sec_regs.svh"
module sec_link
    import sec_pkg::*;
(
    input wire logic sclk,
    input wire logic cs,
    input wire logic rstn,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    sec_job_if.link jb
);
    logic [4:0] cnt_reg, cnt_next;
    logic [`SEC_HDR_BITS-1:0] hdr_reg, hdr_next;
    logic [`SEC_DATA_W-1:0] sh_reg, sh_next;
    logic started_reg, started_next;
    logic wen_reg, wen_next;
    logic reading_reg, reading_next;
    logic pend_reg, pend_next;
    logic hiz_reg, hiz_next;
    logic [1:0] rst_sync_reg;
    logic tgl_reg, tgl_next;
    logic rtgl_reg, rtgl_next;
    sec_job_t job_reg, job_next;
    logic [`SEC_ADDR_W-1:0] addr_reg, addr_next;
    logic [`SEC_DATA_W-1:0] data_reg, data_next;
    logic [1:0] op;
    logic [`SEC_ADDR_W-1:0] a;
    logic prog_job;
    assign op = hdr_reg[`SEC_ADDR_W+1:`SEC_ADDR_W];
    assign a = hdr_reg[`SEC_ADDR_W-1:0];
    assign prog_job = (op == `SEC_OP_WRITE) ||
        (op == `SEC_OP_EXT && a[`SEC_ADDR_W-1 -: 2] == `SEC_EXT_WRALL);
    assign jb.req_tgl = tgl_reg;
    assign jb.job = job_reg;
    assign jb.addr = addr_reg;
    assign jb.data = data_reg;
    assign jb.rd_req_tgl = rtgl_reg;
    assign jb.rd_addr = addr_reg;
    always_comb begin
        cnt_next = cnt_reg;
        hdr_next = hdr_reg;
        sh_next = sh_reg;
        started_next = started_reg;
        wen_next = wen_reg;
        reading_next = reading_reg;
        pend_next = pend_reg;
        rtgl_next = rtgl_reg;
        addr_next = addr_reg;
        if (!started_reg) begin
            if (sdi) begin
                started_next = 1'b1; // [RULE20]
                cnt_next = 5'h1;
            end
        end else if (reading_reg) begin
            // dummy zero has gone out, shift the word msb first
            sh_next = {sh_reg[`SEC_DATA_W-2:0], 1'b1}; // [RULE1] [RULE2]
        end else if (cnt_reg < 5'(`SEC_HDR_BITS - 1)) begin
            hdr_next = {hdr_reg[`SEC_HDR_BITS-2:0], sdi}; // [RULE18]
            cnt_next = cnt_reg + 5'h1;
        end else if (cnt_reg == 5'(`SEC_HDR_BITS - 1)) begin
            // decode on the last address bit: short instructions get no further clock
            hdr_next = {hdr_reg[`SEC_HDR_BITS-2:0], sdi};
            cnt_next = cnt_reg + 5'h1;
            if (hdr_next[`SEC_ADDR_W+1:`SEC_ADDR_W] == `SEC_OP_READ) begin
                addr_next = hdr_next[`SEC_ADDR_W-1:0];
                rtgl_next = ~rtgl_reg;
                reading_next = 1'b1; // [RULE1] [RULE14]
            end else if (hdr_next[`SEC_ADDR_W+1:`SEC_ADDR_W] == `SEC_OP_EXT) begin
                if (hdr_next[`SEC_ADDR_W-1 -: 2] == `SEC_EXT_ENABLE) begin
                    wen_next = 1'b1; // [RULE12]
                end else if (hdr_next[`SEC_ADDR_W-1 -: 2] == `SEC_EXT_DISABLE) begin
                    wen_next = 1'b0; // [RULE12]
                end
            end
            pend_next = wen_reg && (hdr_next[`SEC_ADDR_W+1:`SEC_ADDR_W] == `SEC_OP_ERASE ||
                (hdr_next[`SEC_ADDR_W+1:`SEC_ADDR_W] == `SEC_OP_EXT &&
                hdr_next[`SEC_ADDR_W-1 -: 2] == `SEC_EXT_ERALL)); // [RULE13]
        end else if (prog_job && cnt_reg < 5'(`SEC_HDR_BITS + `SEC_DATA_W)) begin
            sh_next = {sh_reg[`SEC_DATA_W-2:0], sdi}; // [RULE18]
            cnt_next = cnt_reg + 5'h1;
            if (cnt_reg == 5'(`SEC_HDR_BITS + `SEC_DATA_W - 1)) begin
                pend_next = wen_reg; // [RULE13]
            end
        end
    end
    // reading a done read word happens one sclk late, after rd_data settled through the core
    logic rd_load_reg;
    always_ff @(posedge sclk or negedge cs) begin
        if (!cs) begin
            cnt_reg <= 5'h0;
            hdr_reg <= '0;
            started_reg <= 1'b0;
            reading_reg <= 1'b0;
            pend_reg <= 1'b0;
            rd_load_reg <= 1'b0;
            sh_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
            hdr_reg <= hdr_next;
            started_reg <= started_next;
            reading_reg <= reading_next;
            pend_reg <= pend_next;
            rd_load_reg <= reading_next && !reading_reg;
            sh_reg <= (rd_load_reg) ? jb.rd_data : sh_next;
        end
    end
    always_ff @(posedge sclk) begin
        if (!rst_sync_reg[1]) begin
            wen_reg <= 1'b0; // [RULE10]
            rtgl_reg <= 1'b0;
            addr_reg <= '0;
        end else begin
            wen_reg <= wen_next;
            rtgl_reg <= rtgl_next;
            addr_reg <= (pend_next && !pend_reg) ? hdr_next[`SEC_ADDR_W-1:0] : addr_next;
        end
    end
    always_ff @(posedge sclk) begin
        rst_sync_reg <= {rst_sync_reg[0], rstn};
    end
    always_comb begin
        tgl_next = tgl_reg;
        job_next = job_reg;
        data_next = data_reg;
        if (pend_reg) begin
            tgl_next = ~tgl_reg; // [RULE4] [RULE8] [RULE15] [RULE16]
            data_next = sh_reg;
            if (op == `SEC_OP_WRITE) job_next = SEC_JOB_WRITE;
            else if (op == `SEC_OP_ERASE) job_next = SEC_JOB_ERASE;
            else if (a[`SEC_ADDR_W-1 -: 2] == `SEC_EXT_ERALL) job_next = SEC_JOB_ERALL;
            else job_next = SEC_JOB_WRALL;
        end
    end
    // job launches on the falling edge of chip select; reset keeps the toggle defined for the core
    always_ff @(negedge cs or negedge rstn) begin
        if (!rstn) begin
            tgl_reg <= 1'b0;
            job_reg <= SEC_JOB_NONE;
            data_reg <= '0;
        end else begin
            tgl_reg <= tgl_next;
            job_reg <= job_next;
            data_reg <= data_next;
        end
    end
    always_comb begin
        hiz_next = hiz_reg;
        if (started_reg || sdi) hiz_next = 1'b1; // [RULE19]
    end
    always_ff @(negedge sclk or negedge cs) begin
        if (!cs) hiz_reg <= 1'b0;
        else hiz_reg <= hiz_next;
    end
    always_comb begin
        sdo_oe = cs && (reading_reg || !hiz_reg);
        if (reading_reg) sdo = rd_load_reg ? 1'b0 : sh_reg[`SEC_DATA_W-1]; // [RULE1]
        // status follows the engine with no serial clock, as polling gives none
        else sdo = !jb.busy; // [RULE6] [RULE17]
    end
endmodule : sec_link

// File: verilog/sec_regs.svh
// timing counts, instruction layout and array geometry for the serial eeprom command engine
`ifndef SEC_REGS_SVH
`define SEC_REGS_SVH
`define SEC_CLK_MHZ 50
`define SEC_PROG_TIME_US 10000
`define SEC_PROG_CYCLES (`SEC_PROG_TIME_US * `SEC_CLK_MHZ)
`define SEC_ADDR_W 7
`define SEC_DATA_W 16
`define SEC_WORDS 128
`define SEC_OP_W 2
`define SEC_OP_EXT 2'h0
`define SEC_OP_WRITE 2'h1
`define SEC_OP_READ 2'h2
`define SEC_OP_ERASE 2'h3
`define SEC_EXT_DISABLE 2'h0
`define SEC_EXT_WRALL 2'h1
`define SEC_EXT_ERALL 2'h2
`define SEC_EXT_ENABLE 2'h3
`define SEC_HDR_BITS 10
`define SEC_BLANK 16'hFFFF
`endif

// File: verilog/sec_pkg.sv
// types shared by the serial eeprom command engine
`include "sec_regs.svh"
package sec_pkg;
    typedef enum logic [2:0] {
        SEC_JOB_NONE = 3'h0,
        SEC_JOB_WRITE = 3'h1,
        SEC_JOB_ERASE = 3'h2,
        SEC_JOB_ERALL = 3'h3,
        SEC_JOB_WRALL = 3'h4
    } sec_job_t;
    typedef enum logic [1:0] {
        SEC_CORE_IDLE = 2'h0,
        SEC_CORE_CLEAR = 2'h1,
        SEC_CORE_STORE = 2'h3
    } sec_core_t;
endpackage : sec_pkg

// File: verilog/sec_job_if.sv
// job handoff between link-side decoder and core array engine
`timescale 1ns/10ps
interface sec_job_if;
    import sec_pkg::*;
    logic req_tgl;
    sec_job_t job;
    logic [`SEC_ADDR_W-1:0] addr;
    logic [`SEC_DATA_W-1:0] data;
    logic rd_req_tgl;
    logic [`SEC_ADDR_W-1:0] rd_addr;
    logic [`SEC_DATA_W-1:0] rd_data;
    logic busy;
    modport link (output req_tgl, output job, output addr, output data,
                  output rd_req_tgl, output rd_addr, input rd_data, input busy);
    modport core (input req_tgl, input job, input addr, input data,
                  input rd_req_tgl, input rd_addr, output rd_data, output busy);
endinterface : sec_job_if

// File: verilog/sec_core.sv
// memory array and self-timed clear/store engine on the system clock
`timescale 1ns/10ps
`include "sec_regs.svh"
module sec_core
    import sec_pkg::*;
#(
    parameter int PROG_CYCLES = `SEC_PROG_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    sec_job_if.core jb
);
    logic [`SEC_DATA_W-1:0] mem_reg [`SEC_WORDS];
    logic [`SEC_DATA_W-1:0] mem_next [`SEC_WORDS];
    logic [2:0] req_sync_reg, req_sync_next;
    logic [2:0] rd_sync_reg, rd_sync_next;
    sec_core_t st_reg, st_next;
    logic [31:0] cnt_reg, cnt_next;
    logic [`SEC_DATA_W-1:0] rdd_reg, rdd_next;
    logic busy_reg, busy_next;
    logic half;
    assign half = (PROG_CYCLES / 2) > 1;
    assign jb.rd_data = rdd_reg;
    // raw toggle keeps status low from the chip-select fall until the engine has taken the job
    assign jb.busy = busy_reg || (req_sync_reg[2] != jb.req_tgl);
    always_comb begin
        req_sync_next = {req_sync_reg[1:0], jb.req_tgl};
        rd_sync_next = {rd_sync_reg[1:0], jb.rd_req_tgl};
        st_next = st_reg;
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        rdd_next = rdd_reg;
        for (int i = 0; i < `SEC_WORDS; i++) begin
            mem_next[i] = mem_reg[i];
        end
        // job fields are stable from the toggle until ready is seen, so reading them here is safe
        if (rd_sync_reg[2] != rd_sync_reg[1]) begin
            rdd_next = mem_reg[jb.rd_addr]; // [RULE14]
        end
        case (st_reg)
            SEC_CORE_IDLE: begin
                if (req_sync_reg[2] != req_sync_reg[1]) begin
                    busy_next = 1'b1;
                    cnt_next = PROG_CYCLES / 2;
                    st_next = SEC_CORE_CLEAR; // [RULE4] [RULE5]
                end
            end
            SEC_CORE_CLEAR: begin
                if (cnt_reg <= 32'h1 || !half) begin
                    // every write first blanks its target, no separate erase needed
                    if (jb.job == SEC_JOB_WRITE || jb.job == SEC_JOB_ERASE) begin
                        mem_next[jb.addr] = `SEC_BLANK; // [RULE7] [RULE8] [RULE9]
                    end else if (jb.job == SEC_JOB_ERALL || jb.job == SEC_JOB_WRALL) begin
                        for (int i = 0; i < `SEC_WORDS; i++) begin
                            mem_next[i] = `SEC_BLANK; // [RULE15] [RULE16]
                        end
                    end
                    cnt_next = PROG_CYCLES - PROG_CYCLES / 2;
                    st_next = SEC_CORE_STORE;
                end else begin
                    cnt_next = cnt_reg - 32'h1;
                end
            end
            SEC_CORE_STORE: begin
                if (cnt_reg <= 32'h1) begin
                    if (jb.job == SEC_JOB_WRITE) begin
                        mem_next[jb.addr] = jb.data; // [RULE4]
                    end else if (jb.job == SEC_JOB_WRALL) begin
                        for (int i = 0; i < `SEC_WORDS; i++) begin
                            mem_next[i] = jb.data; // [RULE16]
                        end
                    end
                    busy_next = 1'b0;
                    st_next = SEC_CORE_IDLE;
                end else begin
                    cnt_next = cnt_reg - 32'h1;
                end
            end
            default: st_next = SEC_CORE_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            req_sync_reg <= 3'h0;
            rd_sync_reg <= 3'h0;
            st_reg <= SEC_CORE_IDLE;
            cnt_reg <= 32'h0;
            busy_reg <= 1'b0;
            rdd_reg <= `SEC_BLANK;
        end else begin
            req_sync_reg <= req_sync_next;
            rd_sync_reg <= rd_sync_next;
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            rdd_reg <= rdd_next;
        end
    end
    // array contents survive reset, as a nonvolatile store would
    always_ff @(posedge clk) begin
        for (int i = 0; i < `SEC_WORDS; i++) begin
            mem_reg[i] <= mem_next[i];
        end
    end
endmodule : sec_core

// File: verilog/sec_top.sv
// serial eeprom command engine top: link on the serial clock, array on the system clock
// Operation
// RULE1: read shifts out a leading zero then the addressed word msb first
// RULE2: read bits change on rising serial clock
// RULE3: host drops chip select for the minimum low time after programming
// RULE4: chip select fall after program starts self-timed clear then store
// RULE5: self-timed cycles need no serial clock pulses
// RULE6: host polls busy state on data output with chip select high
// RULE7: program clears the location first automatically
// RULE8: erase starts a self-timed clear of one location on chip select fall
// RULE9: cleared bits read as one
// RULE10: write-enable latch starts disabled
// RULE11: host sends enable before program or clear instructions
// RULE12: enable latch stays set until disable instruction or power loss
// RULE13: program, write-all, erase, erase-all ignored while latch cleared
// RULE14: reads work regardless of latch state
// RULE15: erase-all clears every bit to one on chip select fall
// RULE16: write-all programs data into every location without prior clear; the core still clears every word to one before the store
// RULE17: busy drives output low, ready drives it high
// RULE18: input bits sampled on rising serial clock
// RULE19: a one shifted in while selected floats the output on next falling clock
// RULE20: instructions start with a one start bit then opcode, address, data
// RULE21: host waits for ready before the next instruction
`timescale 1ns/10ps
`include "sec_regs.svh"
module sec_top
    import sec_pkg::*;
#(
    parameter int PROG_CYCLES = `SEC_PROG_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic cs,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe
);
    sec_job_if jb ();
    sec_link u_link (
        .sclk(sclk),
        .cs(cs),
        .rstn(rstn),
        .sdi(sdi),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .jb(jb.link)
    );
    sec_core #(
        .PROG_CYCLES(PROG_CYCLES)
    ) u_core (
        .clk(clk),
        .rstn(rstn),
        .jb(jb.core)
    );
endmodule : sec_top

// File: verif/sec_props.sv
// concurrent checks on the serial pins of the link side
`timescale 1ns/10ps
`include "sec_regs.svh"
module sec_link_props (
    input wire logic sclk,
    input wire logic cs,
    input wire logic rstn,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    logic [4:0] cnt_reg, cnt_next;
    logic [1:0] op_reg, op_next;
    logic rd;
    always_comb begin
        cnt_next = cnt_reg;
        op_next = op_reg;
        if (cnt_reg != 5'h00 || sdi) begin
            cnt_next = (cnt_reg == 5'h1F) ? cnt_reg : cnt_reg + 5'h01;
        end
        if (cnt_reg == 5'h01 || cnt_reg == 5'h02) begin
            op_next = {op_reg[0], sdi};
        end
    end
    // cleared by chip select, since sclk stands still between frames
    always_ff @(posedge sclk or negedge cs or negedge rstn) begin
        if (!cs || !rstn) begin
            cnt_reg <= 5'h00;
            op_reg <= 2'h0;
        end else begin
            cnt_reg <= cnt_next;
            op_reg <= op_next;
        end
    end
    assign rd = (op_reg == `SEC_OP_READ);
    a_float_on_one: assert property (@(posedge sclk) disable iff (!rstn)
        cs && cnt_reg == 5'h00 && sdi && sdo_oe |=> !sdo_oe || cnt_reg == 5'h00)
        else $error("output not floated after a one");
    a_hdr_quiet: assert property (@(posedge sclk) disable iff (!rstn)
        cnt_reg inside {[5'h01:5'h08]} |=> !sdo_oe || cnt_reg == 5'h00)
        else $error("output driven inside header");
    a_lead_zero: assert property (@(posedge sclk) disable iff (!rstn)
        rd && cnt_reg == 5'h09 |=> sdo_oe && !sdo)
        else $error("no leading zero on read");
    a_word_driven: assert property (@(posedge sclk) disable iff (!rstn)
        rd && cnt_reg >= 5'h0A && cnt_reg <= 5'h19 |=> sdo_oe)
        else $error("read word not driven");
    a_write_quiet: assert property (@(posedge sclk) disable iff (!rstn)
        op_reg == `SEC_OP_WRITE && cnt_reg >= 5'h09 |=> !sdo_oe || cnt_reg == 5'h00)
        else $error("output driven during write data");
    a_ext_quiet: assert property (@(posedge sclk) disable iff (!rstn)
        op_reg == `SEC_OP_EXT && cnt_reg >= 5'h09 |=> !sdo_oe || cnt_reg == 5'h00)
        else $error("output driven during extended data");
    a_oe_cause: assert property (@(posedge sclk) disable iff (!rstn)
        $rose(sdo_oe) && cnt_reg != 5'h00 |-> rd && cnt_reg == 5'h0A)
        else $error("output enabled without read");
    a_status_driven: assert property (@(posedge sclk) disable iff (!rstn)
        cs && cnt_reg == 5'h00 |-> sdo_oe)
        else $error("status not driven while selected");
endmodule : sec_link_props
bind sec_top sec_link_props chk_u (.sclk(sclk), .cs(cs), .rstn(rstn), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe));

// File: verif/sec_host_model.sv
// host model: drives chip select, serial clock and data in, samples data out
`timescale 1ns/10ps
`include "sec_regs.svh"
module sec_host_model (
    output logic cs,
    output logic sclk,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    initial begin
        cs = 1'b0;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // data moves after the fall so it is settled at the sampling rise
    task automatic tick(input logic b);
        sdi = b;
        #6 sclk = 1'b1;
        #6 sclk = 1'b0;
    endtask : tick
    task automatic shift(input logic [25:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            tick(v[i]);
        end
    endtask : shift
    task automatic open_frame();
        #5 cs = 1'b1;
        #25;
    endtask : open_frame
    // long deselect covers the minimum low time; released data line flips
    task automatic close_frame();
        #4 cs = 1'b0;
        sdi = ~sdi;
        #200;
    endtask : close_frame
    task automatic cmd(input logic [1:0] op, input logic [6:0] a, input logic [15:0] d);
        open_frame();
        if (op == `SEC_OP_WRITE || (op == `SEC_OP_EXT && a[6:5] == `SEC_EXT_WRALL)) begin
            shift({1'b1, op, a, d}, 26);
        end else begin
            shift({16'h0000, 1'b1, op, a}, 10);
        end
        close_frame();
    endtask : cmd
    task automatic read(input logic [6:0] a, output logic lead, output logic [15:0] w);
        open_frame();
        shift({16'h0000, 1'b1, `SEC_OP_READ, a}, 10);
        sdi = 1'b0;
        // clock held low a while to leave room for the array fetch
        #100 lead = sdo_oe ? sdo : 1'bx;
        for (int i = 15; i >= 0; i--) begin
            tick(1'b0);
            #5 w[i] = sdo_oe ? sdo : 1'bx;
        end
        close_frame();
    endtask : read
    // no clock pulses while waiting: the cycle is self-timed
    task automatic poll(output logic first, output int waits, output logic fl);
        open_frame();
        first = sdo_oe ? sdo : 1'bx;
        waits = 0;
        while (sdo !== 1'b1 && waits < 5000) begin
            #20 waits++;
        end
        tick(1'b1);
        #1 fl = (sdo_oe === 1'b0);
        tick(1'b0);
        close_frame();
    endtask : poll
endmodule : sec_host_model

// File: verif/sec_tb.sv
// self-checking bench: host model on the link, short program time on the array
`timescale 1ns/10ps
`include "sec_regs.svh"
module testbench;
    localparam int PROG = 500;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    wire cs, sclk, sdi, sdo, sdo_oe;
    int num_errors = 0;
    int checks_done = 0;
    sec_top #(.PROG_CYCLES(PROG)) dut_u (.clk(clk), .rstn(rstn), .sclk(sclk), .cs(cs),
        .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
    sec_host_model host_u (.cs(cs), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
    always #10 clk = ~clk;
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        logic lead;
        logic [15:0] w;
        host_u.read(a, lead, w);
        check({15'h0000, lead}, 16'h0000);
        check(w, exp);
    endtask : rd
    // busy is expected only where the latch lets the instruction through
    task automatic op(input logic [1:0] o, input logic [6:0] a, input logic [15:0] d,
        input logic busy);
        logic first, fl;
        int w;
        host_u.cmd(o, a, d);
        host_u.poll(first, w, fl);
        check({15'h0000, first}, {15'h0000, !busy});
        check({15'h0000, w > 0 && w <= PROG + 50}, {15'h0000, busy});
        check({15'h0000, fl}, 16'h0001);
    endtask : op
    task automatic t_locked();
        op(`SEC_OP_WRITE, 7'h03, 16'h0000, 1'b0);
    endtask : t_locked
    task automatic t_erase_all();
        op(`SEC_OP_EXT, {`SEC_EXT_ENABLE, 5'h00}, 16'h0000, 1'b0);
        op(`SEC_OP_EXT, {`SEC_EXT_ERALL, 5'h00}, 16'h0000, 1'b1);
        rd(7'h00, `SEC_BLANK);
        rd(7'h7F, `SEC_BLANK);
    endtask : t_erase_all
    task automatic t_write();
        op(`SEC_OP_WRITE, 7'h12, 16'hA5C3, 1'b1);
        rd(7'h12, 16'hA5C3);
        op(`SEC_OP_WRITE, 7'h12, 16'h5A3C, 1'b1);
        rd(7'h12, 16'h5A3C);
        rd(7'h13, `SEC_BLANK);
    endtask : t_write
    task automatic t_erase();
        op(`SEC_OP_ERASE, 7'h12, 16'h0000, 1'b1);
        rd(7'h12, `SEC_BLANK);
    endtask : t_erase
    task automatic t_write_all();
        op(`SEC_OP_EXT, {`SEC_EXT_WRALL, 5'h00}, 16'h3C96, 1'b1);
        rd(7'h00, 16'h3C96);
        rd(7'h12, 16'h3C96);
        rd(7'h7F, 16'h3C96);
    endtask : t_write_all
    task automatic t_disabled();
        op(`SEC_OP_EXT, {`SEC_EXT_DISABLE, 5'h00}, 16'h0000, 1'b0);
        op(`SEC_OP_WRITE, 7'h05, 16'h0000, 1'b0);
        op(`SEC_OP_ERASE, 7'h05, 16'h0000, 1'b0);
        op(`SEC_OP_EXT, {`SEC_EXT_ERALL, 5'h00}, 16'h0000, 1'b0);
        op(`SEC_OP_EXT, {`SEC_EXT_WRALL, 5'h00}, 16'h0000, 1'b0);
        rd(7'h05, 16'h3C96);
    endtask : t_disabled
    initial begin
        host_u.shift(26'h0000000, 4);
        repeat (20) @(posedge clk);
        #2 rstn = 1'b1;
        t_locked();
        t_erase_all();
        t_write();
        t_erase();
        t_write_all();
        t_disabled();
        wrap_up();
    end
    initial begin
        #1000000;
        num_errors++;
        wrap_up();
    end
endmodule : testbench
